// ===== inc/fps_regs.vh
// Register map, field positions, codes and timing counts of the front panel supervisor.
// Assumes a 50 MHz clock and a 32-bit AXI4-Lite register bus.
`ifndef FPS_REGS_VH
`define FPS_REGS_VH
`define FPS_CLK_HZ 50000000
`define FPS_DEBOUNCE_MS 5
`define FPS_DEBOUNCE_CYC ((`FPS_CLK_HZ / 1000) * `FPS_DEBOUNCE_MS)
`define FPS_SVC_IDLE_S 10
`define FPS_SVC_IDLE_CYC (`FPS_CLK_HZ * `FPS_SVC_IDLE_S)
`define FPS_HOLD_DEF_S 8'h03
`define FPS_FLASH_CYC (`FPS_CLK_HZ / 4)
`define FPS_NMI_CYC 16'h03E8
`define FPS_ADDR_CTRL 4'h0
`define FPS_ADDR_HOLD 4'h4
`define FPS_ADDR_STAT 4'h8
`define FPS_ADDR_LCD 4'hC
`define FPS_CTRL_SEC_EN 0
`define FPS_CTRL_INT_ALARM 1
`define FPS_CTRL_PWR_ALARM 2
`define FPS_CTRL_BOOT_DONE 3
`define FPS_CTRL_MODEM_OK 4
`define FPS_CTRL_MODEM_FAIL 5
`define FPS_CTRL_MODEM_ALT 6
`define FPS_CTRL_RESET 32'h0000_0000
`define FPS_CODE_RUN 16'h0000
`define FPS_CODE_STANDBY 16'h1200
`define FPS_CODE_RESET 16'h1400
`define FPS_CODE_SERVICE 16'h8888
`define FPS_CODE_MODEM_E1 16'h0F4D
`define FPS_CODE_MODEM_E2 16'h0F4E
`define FPS_CODE_BLANK 16'hFFFF
`define FPS_RESP_OKAY 2'h0
`define FPS_RESP_SLVERR 2'h2
`endif

// ===== design/fps_front_panel.v
// Front panel supervisor: buttons, lock sensors, tone, LEDs, LCD code and host controls.
// Assumes one 50 MHz clock, raw asynchronous pins and an AXI4-Lite master for settings.
// Functional notes
// RULE_01 - Power-on in standby turns system on
// RULE_02 - Control silences internal and power alarms
// RULE_03 - Control at boot selects EPROM image
// RULE_04 - Standby hold shows 1200 with tone
// RULE_05 - Shutdown only after full standby hold
// RULE_06 - Standby plus control cancels standby sequence
// RULE_07 - Accepted standby requests OS shutdown, timer runs
// RULE_08 - Reset hold shows 1400, reset after tone
// RULE_09 - Reset plus control cancels reset sequence
// RULE_10 - Three buttons, door unlocked, enter service
// RULE_11 - Service standby or reset pulses NMI
// RULE_12 - Service control initialises modem, shows result
// RULE_13 - Service standby plus reset resets controller
// RULE_14 - Ten idle seconds leave service mode
// RULE_15 - UPS LED green steady or flashing
// RULE_16 - UPS LED amber steady, flashing or off
// RULE_17 - Power LED green when on
// RULE_18 - Locked door with security arms alarm
// RULE_19 - Unlocking door disarms and unblanks
// RULE_20 - Token card toggles blanking, silences alarm
// RULE_21 - Violations while armed sound alarm
// RULE_22 - Lock then unlock silences alarm
// RULE_23 - Debounce every button and sensor
`timescale 1ns/10ps
`default_nettype none
`include "fps_regs.vh"
module fps_front_panel #(
  parameter DEB_CYC = `FPS_DEBOUNCE_CYC,
  parameter SEC_CYC = `FPS_CLK_HZ,
  parameter SVC_IDLE_CYC = `FPS_SVC_IDLE_CYC,
  parameter FLASH_CYC = `FPS_FLASH_CYC
) (
  input wire aclk,
  input wire aresetn,
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire btn_power_on,
  input wire btn_standby,
  input wire btn_control,
  input wire btn_reset,
  input wire door_closed,
  input wire door_key_locked,
  input wire panel_removed,
  input wire token_card,
  input wire mains_ok,
  input wire batt_full,
  input wire batt_low,
  input wire batt_connected,
  output reg sys_power_on,
  output reg host_boot_release,
  output reg host_os_shutdown_req,
  output reg host_hw_reset,
  output reg host_nmi,
  output reg mgmt_ctrl_reset,
  output reg use_eprom_image,
  output reg modem_init_req,
  output reg [15:0] lcd_code,
  output reg tone,
  output reg alarm,
  output reg screen_blank,
  output reg keyboard_disable,
  output reg led_power_green,
  output reg led_ups_green,
  output reg led_ups_amber
);
  localparam NIN = 12;
  localparam ST_OFF = 3'h0;
  localparam ST_ON = 3'h1;
  localparam ST_SBY_HOLD = 3'h2;
  localparam ST_SBY_RUN = 3'h3;
  localparam ST_RST_HOLD = 3'h4;
  localparam ST_SERVICE = 3'h5;
  localparam ST_SVC_MCRST = 3'h6;

  // Two-flop synchronisers, then a per-input stable counter.
  reg [NIN-1:0] sync1_reg, sync2_reg, deb_reg, deb_prev_reg;
  reg [31:0] deb_cnt_reg [0:NIN-1];
  wire [NIN-1:0] raw_in = {batt_connected, batt_low, batt_full, mains_ok, token_card,
    panel_removed, door_key_locked, door_closed, btn_reset, btn_control, btn_standby,
    btn_power_on};
  integer i;
  always @(posedge aclk) begin
    sync1_reg <= raw_in;
    sync2_reg <= sync1_reg;
  end
  // RULE_23 debounce filter
  always @(posedge aclk) begin
    if (!aresetn) begin
      deb_reg <= {NIN{1'b0}};
      deb_prev_reg <= {NIN{1'b0}};
      for (i = 0; i < NIN; i = i + 1)
        deb_cnt_reg[i] <= 32'h0000_0000;
    end else begin
      deb_prev_reg <= deb_reg;
      for (i = 0; i < NIN; i = i + 1) begin
        if (sync2_reg[i] == deb_reg[i])
          deb_cnt_reg[i] <= 32'h0000_0000;
        else if (deb_cnt_reg[i] >= DEB_CYC - 1) begin
          deb_reg[i] <= sync2_reg[i];
          deb_cnt_reg[i] <= 32'h0000_0000;
        end else
          deb_cnt_reg[i] <= deb_cnt_reg[i] + 32'h0000_0001;
      end
    end
  end
  wire b_pwr = deb_reg[0];
  wire b_sby = deb_reg[1];
  wire b_ctl = deb_reg[2];
  wire b_rst = deb_reg[3];
  wire d_closed = deb_reg[4];
  wire d_locked = deb_reg[5];
  wire any_btn = |deb_reg[3:0];
  wire [NIN-1:0] rise = deb_reg & ~deb_prev_reg;
  wire [NIN-1:0] fall = ~deb_reg & deb_prev_reg;

  // Registers.
  reg [31:0] ctrl_reg;
  reg [7:0] sby_hold_reg, rst_hold_reg;
  reg [2:0] st_reg;
  reg sec_armed, sec_alarm_reg, card_unblank_reg, prev_locked_reg;

  // Bus slave: address and data may come in either order; both are latched.
  reg aw_got_reg, w_got_reg;
  reg [3:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  wire do_write = aw_got_reg && w_got_reg && !s_axi_bvalid;
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer k;
    begin
      for (k = 0; k < 4; k = k + 1)
        merge[k*8 +: 8] = strb[k] ? nw[k*8 +: 8] : old[k*8 +: 8];
    end
  endfunction
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `FPS_RESP_OKAY;
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      aw_addr_reg <= 4'h0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      ctrl_reg <= `FPS_CTRL_RESET;
      sby_hold_reg <= `FPS_HOLD_DEF_S;
      rst_hold_reg <= `FPS_HOLD_DEF_S;
    end else begin
      s_axi_awready <= !aw_got_reg && s_axi_awvalid && !s_axi_awready;
      s_axi_wready <= !w_got_reg && s_axi_wvalid && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `FPS_RESP_OKAY;
        case (aw_addr_reg)
          `FPS_ADDR_CTRL: ctrl_reg <= merge(ctrl_reg, w_data_reg, w_strb_reg);
          `FPS_ADDR_HOLD: begin
            if (w_strb_reg[0])
              sby_hold_reg <= w_data_reg[7:0];
            if (w_strb_reg[1])
              rst_hold_reg <= w_data_reg[15:8];
          end
          `FPS_ADDR_STAT, `FPS_ADDR_LCD: s_axi_bresp <= `FPS_RESP_OKAY;
          default: s_axi_bresp <= `FPS_RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      // RULE_02 control press clears internal alarms
      if (st_reg != ST_SERVICE && rise[2] && !sec_armed) begin
        ctrl_reg[`FPS_CTRL_INT_ALARM] <= 1'b0;
        ctrl_reg[`FPS_CTRL_PWR_ALARM] <= 1'b0;
      end
      // RULE_16 mains failure raises the power alarm
      if (fall[8])
        ctrl_reg[`FPS_CTRL_PWR_ALARM] <= 1'b1;
    end
  end
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `FPS_RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `FPS_RESP_OKAY;
        case (s_axi_araddr)
          `FPS_ADDR_CTRL: s_axi_rdata <= ctrl_reg;
          `FPS_ADDR_HOLD: s_axi_rdata <= {16'h0000, rst_hold_reg, sby_hold_reg};
          `FPS_ADDR_STAT: s_axi_rdata <= {16'h0000, deb_reg, 1'b0, st_reg};
          `FPS_ADDR_LCD: s_axi_rdata <= {16'h0000, lcd_code};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `FPS_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // Security: armed while enabled, door closed and key-locked.
  wire sec_cond = ctrl_reg[`FPS_CTRL_SEC_EN] && d_closed && d_locked;
  always @(posedge aclk) begin
    if (!aresetn) begin
      sec_armed <= 1'b0;
      sec_alarm_reg <= 1'b0;
      card_unblank_reg <= 1'b0;
      prev_locked_reg <= 1'b0;
    end else begin
      // RULE_18 arm on locked door
      sec_armed <= sec_cond;
      prev_locked_reg <= d_locked;
      if (!sec_cond)
        card_unblank_reg <= 1'b0;
      // RULE_20 token toggles blanking
      else if (rise[7])
        card_unblank_reg <= ~card_unblank_reg;
      // RULE_19 RULE_22 key unlock silences
      if (prev_locked_reg && !d_locked)
        sec_alarm_reg <= 1'b0;
      else if (sec_armed && rise[7])
        sec_alarm_reg <= 1'b0;
      // RULE_21 violations set alarm
      else if (sec_armed && (!d_closed || rise[6] || (|rise[3:0])))
        sec_alarm_reg <= 1'b1;
      else if (sec_armed && deb_reg[6])
        sec_alarm_reg <= 1'b1;
    end
  end

  // Main sequencer.
  reg [31:0] tmr_reg;
  reg [7:0] sec_cnt_reg;
  reg [15:0] nmi_cnt_reg;
  reg combo_seen_reg;
  wire sec_tick = (tmr_reg >= SEC_CYC - 1);
  wire sby_cancel = b_sby && b_ctl;
  wire rst_cancel = b_rst && b_ctl;
  always @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= ST_OFF;
      tmr_reg <= 32'h0000_0000;
      sec_cnt_reg <= 8'h00;
      nmi_cnt_reg <= 16'h0000;
      combo_seen_reg <= 1'b0;
      sys_power_on <= 1'b0;
      host_boot_release <= 1'b0;
      host_os_shutdown_req <= 1'b0;
      host_hw_reset <= 1'b0;
      host_nmi <= 1'b0;
      mgmt_ctrl_reset <= 1'b0;
      use_eprom_image <= 1'b0;
      modem_init_req <= 1'b0;
      lcd_code <= `FPS_CODE_RUN;
    end else begin
      tmr_reg <= sec_tick ? 32'h0000_0000 : tmr_reg + 32'h0000_0001;
      host_hw_reset <= 1'b0;
      modem_init_req <= 1'b0;
      mgmt_ctrl_reset <= 1'b0;
      // RULE_03 control at boot end picks EPROM
      if (rise[2] == 1'b0 && b_ctl && ctrl_reg[`FPS_CTRL_BOOT_DONE] && !use_eprom_image &&
          st_reg == ST_ON && sec_cnt_reg == 8'h00)
        use_eprom_image <= 1'b1;
      // RULE_11 NMI pulse width
      if (nmi_cnt_reg != 16'h0000) begin
        nmi_cnt_reg <= nmi_cnt_reg - 16'h0001;
        host_nmi <= (nmi_cnt_reg != 16'h0001);
      end
      // RULE_12 modem result code
      if (do_write && aw_addr_reg == `FPS_ADDR_CTRL) begin
        if (w_data_reg[`FPS_CTRL_MODEM_OK])
          lcd_code <= `FPS_CODE_RUN;
        else if (w_data_reg[`FPS_CTRL_MODEM_FAIL])
          lcd_code <= w_data_reg[`FPS_CTRL_MODEM_ALT] ? `FPS_CODE_MODEM_E2 : `FPS_CODE_MODEM_E1;
      end
      case (st_reg)
        ST_OFF: begin
          // RULE_01 power-on from standby
          if (rise[0]) begin
            st_reg <= ST_ON;
            sys_power_on <= 1'b1;
            host_boot_release <= 1'b1;
            lcd_code <= `FPS_CODE_RUN;
          end
        end
        ST_ON: begin
          tmr_reg <= 32'h0000_0000;
          sec_cnt_reg <= 8'h00;
          combo_seen_reg <= 1'b0;
          // RULE_10 enter service mode
          if (b_sby && b_ctl && b_rst && !d_locked) begin
            st_reg <= ST_SERVICE;
            lcd_code <= `FPS_CODE_SERVICE;
          end else if (rise[1] && !b_ctl && !b_rst && !sec_armed) begin
            // RULE_04 standby hold code
            st_reg <= ST_SBY_HOLD;
            lcd_code <= `FPS_CODE_STANDBY;
          end else if (rise[3] && !b_ctl && !b_sby && !sec_armed) begin
            // RULE_08 reset hold code
            st_reg <= ST_RST_HOLD;
            lcd_code <= `FPS_CODE_RESET;
          end else if (rise[2] && !sec_armed)
            lcd_code <= `FPS_CODE_RUN;
        end
        ST_SBY_HOLD: begin
          if (sec_tick)
            sec_cnt_reg <= sec_cnt_reg + 8'h01;
          // RULE_06 cancel standby
          if (sby_cancel || !b_sby) begin
            st_reg <= ST_ON;
            lcd_code <= `FPS_CODE_RUN;
          end else if (sec_cnt_reg >= sby_hold_reg) begin
            // RULE_05 RULE_07 accepted, ask OS to shut down
            st_reg <= ST_SBY_RUN;
            host_os_shutdown_req <= 1'b1;
            sec_cnt_reg <= 8'h00;
          end
        end
        ST_SBY_RUN: begin
          // RULE_07 timer keeps running regardless of host
          if (sec_tick)
            sec_cnt_reg <= sec_cnt_reg + 8'h01;
          if (sec_cnt_reg >= sby_hold_reg) begin
            st_reg <= ST_OFF;
            sys_power_on <= 1'b0;
            host_boot_release <= 1'b0;
            host_os_shutdown_req <= 1'b0;
            use_eprom_image <= 1'b0;
          end
        end
        ST_RST_HOLD: begin
          if (sec_tick)
            sec_cnt_reg <= sec_cnt_reg + 8'h01;
          // RULE_09 cancel reset
          if (rst_cancel || !b_rst) begin
            st_reg <= ST_ON;
            lcd_code <= `FPS_CODE_RUN;
          end else if (sec_cnt_reg >= rst_hold_reg) begin
            st_reg <= ST_ON;
            host_hw_reset <= 1'b1;
          end
        end
        ST_SERVICE: begin
          tmr_reg <= any_btn ? 32'h0000_0000 : tmr_reg + 32'h0000_0001;
          // RULE_14 idle exit
          if (!any_btn && tmr_reg >= SVC_IDLE_CYC - 1) begin
            st_reg <= ST_ON;
            lcd_code <= `FPS_CODE_RUN;
          end else if (b_sby && b_rst && !b_ctl) begin
            // RULE_13 clear LCD, reset on release
            lcd_code <= `FPS_CODE_BLANK;
            st_reg <= ST_SVC_MCRST;
          end else if (any_btn == 1'b0 && combo_seen_reg) begin
            combo_seen_reg <= 1'b0;
          end else if (!any_btn) begin
            combo_seen_reg <= 1'b0;
          end else if (!combo_seen_reg && (b_sby ^ b_rst) && !b_ctl) begin
            // RULE_11 assert then release NMI
            combo_seen_reg <= 1'b1;
            host_nmi <= 1'b1;
            nmi_cnt_reg <= `FPS_NMI_CYC;
          end else if (!combo_seen_reg && b_ctl && !b_sby && !b_rst) begin
            // RULE_12 start modem initialisation
            combo_seen_reg <= 1'b1;
            modem_init_req <= 1'b1;
          end
        end
        ST_SVC_MCRST: begin
          tmr_reg <= 32'h0000_0000;
          if (!b_sby && !b_rst) begin
            mgmt_ctrl_reset <= 1'b1;
            st_reg <= ST_ON;
          end
        end
        default: st_reg <= ST_OFF;
      endcase
    end
  end

  // LEDs, tone and security outputs.
  reg [31:0] flash_cnt_reg;
  reg flash_reg;
  always @(posedge aclk) begin
    if (!aresetn) begin
      flash_cnt_reg <= 32'h0000_0000;
      flash_reg <= 1'b0;
      tone <= 1'b0;
      alarm <= 1'b0;
      screen_blank <= 1'b0;
      keyboard_disable <= 1'b0;
      led_power_green <= 1'b0;
      led_ups_green <= 1'b0;
      led_ups_amber <= 1'b0;
    end else begin
      if (flash_cnt_reg >= FLASH_CYC - 1) begin
        flash_cnt_reg <= 32'h0000_0000;
        flash_reg <= ~flash_reg;
      end else
        flash_cnt_reg <= flash_cnt_reg + 32'h0000_0001;
      // RULE_04 RULE_08 tone during hold
      tone <= (st_reg == ST_SBY_HOLD) || (st_reg == ST_RST_HOLD);
      // RULE_02 RULE_16 alarm sources
      alarm <= sec_alarm_reg || ctrl_reg[`FPS_CTRL_INT_ALARM] ||
        ctrl_reg[`FPS_CTRL_PWR_ALARM];
      // RULE_18 RULE_19 RULE_20 blanking
      screen_blank <= sec_cond && !card_unblank_reg;
      keyboard_disable <= sec_cond && !card_unblank_reg;
      // RULE_17 power LED
      led_power_green <= sys_power_on;
      // RULE_15 RULE_16 UPS LED
      led_ups_green <= deb_reg[11] && deb_reg[8] && (deb_reg[9] || flash_reg);
      led_ups_amber <= deb_reg[11] && !deb_reg[8] && (!deb_reg[10] || flash_reg);
    end
  end
endmodule
`default_nettype wire

// ===== verif/fps_front_panel_props.sv
// Concurrent checks on the front panel supervisor outputs.
// Assumes it is bound to fps_front_panel and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module fps_props #(
  parameter int DEB_CYC = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic batt_connected,
  input wire logic sys_power_on,
  input wire logic host_boot_release,
  input wire logic host_os_shutdown_req,
  input wire logic host_hw_reset,
  input wire logic host_nmi,
  input wire logic mgmt_ctrl_reset,
  input wire logic screen_blank,
  input wire logic keyboard_disable,
  input wire logic led_power_green,
  input wire logic led_ups_green,
  input wire logic led_ups_amber
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic [31:0] off_cnt;
  // The raw sensor passes the synchroniser and debounce before the LED may react.
  always @(posedge aclk) begin
    if (!aresetn || batt_connected) off_cnt <= 32'h0;
    else if (off_cnt < DEB_CYC + 8) off_cnt <= off_cnt + 32'h1;
  end
  AST_BOOT_RELEASE: assert property ($rose(sys_power_on) |-> ##[0:2] host_boot_release)
    else $error("boot release missing after power on");
  AST_POWER_LED: assert property (sys_power_on && $past(sys_power_on, 2) |-> led_power_green)
    else $error("power LED dark while system on");
  AST_NMI_PULSE: assert property ($rose(host_nmi) |-> host_nmi [*8])
    else $error("NMI pulse too short");
  AST_HW_RESET_ONE: assert property (host_hw_reset |=> !host_hw_reset)
    else $error("hardware reset not a single pulse");
  AST_MGMT_RESET_ONE: assert property (mgmt_ctrl_reset |=> (!mgmt_ctrl_reset) [*4])
    else $error("controller reset repeated");
  AST_SHUT_WHILE_ON: assert property ($rose(host_os_shutdown_req) |-> sys_power_on)
    else $error("shutdown request while off");
  AST_SHUT_UNTIL_OFF: assert property ($fell(host_os_shutdown_req) |-> ##[0:1] !sys_power_on)
    else $error("shutdown request dropped while still on");
  AST_BLANK_KBD: assert property (screen_blank == keyboard_disable)
    else $error("blanking and keyboard lock disagree");
  AST_UPS_OFF: assert property (off_cnt == DEB_CYC + 8 |-> !led_ups_green && !led_ups_amber)
    else $error("UPS LED lit with battery disconnected");
  AST_UPS_ONE_COLOUR: assert property (!(led_ups_green && led_ups_amber))
    else $error("UPS LED green and amber together");
  cover property ($rose(host_nmi));
  cover property (host_hw_reset);
  cover property ($fell(sys_power_on));
endmodule
bind fps_front_panel fps_props #(.DEB_CYC(DEB_CYC)) props_u (
  .aclk,
  .aresetn,
  .batt_connected,
  .sys_power_on,
  .host_boot_release,
  .host_os_shutdown_req,
  .host_hw_reset,
  .host_nmi,
  .mgmt_ctrl_reset,
  .screen_blank,
  .keyboard_disable,
  .led_power_green,
  .led_ups_green,
  .led_ups_amber
);
`default_nettype wire

// ===== verif/fps_panel_model.sv
// Operator and sensor model: buttons, door and panel sensors, token card and UPS status.
// Assumes the bench clock; every change lands by non-blocking assignment after an edge.
`timescale 1ns/10ps
`default_nettype none
module fps_panel_model (
  input wire logic aclk,
  input wire logic tone,
  output logic [3:0] btn,
  output logic [7:0] sens
);
  initial begin
    btn = 4'h0;
    sens = 8'h8D;
  end
  task set_btn(input logic [3:0] m);
    @(posedge aclk);
    btn <= m;
  endtask
  task set_sens(input logic [7:0] s);
    @(posedge aclk);
    sens <= s;
  endtask
  task hold_tone(input logic [3:0] m);
    int k;
    set_btn(m);
    k = 0;
    while (tone !== 1'b1 && k < 100) begin
      @(posedge aclk);
      k++;
    end
    while (tone !== 1'b0 && k < 400) begin
      @(posedge aclk);
      k++;
    end
    set_btn(4'h0);
  endtask
endmodule
`default_nettype wire

// ===== verif/tb.sv
// Self-checking bench of the front panel supervisor: bus tasks, panel scenarios, verdict.
// Assumes the partner model drives the pins and the checker is bound to the design.
`timescale 1ns/10ps
`default_nettype none
`include "fps_regs.vh"
module tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0;
  logic s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_wvalid = 1'b0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_bready = 1'b0;
  logic [3:0] s_axi_araddr = 4'h0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic [31:0] s_axi_rdata, rd;
  logic sys_power_on, host_boot_release, host_os_shutdown_req, host_hw_reset, host_nmi;
  logic mgmt_ctrl_reset, use_eprom_image, modem_init_req, tone, alarm, screen_blank;
  logic keyboard_disable, led_power_green, led_ups_green, led_ups_amber;
  logic [15:0] lcd_code;
  logic [3:0] btn;
  logic [7:0] sens;
  logic [8:0] ev, ev_q;
  int rises [9];
  int cyc = 0;
  int err_total = 0;
  int check_count = 0;
  logic [31:0] mw [3] = '{32'h20, 32'h60, 32'h10};
  logic [15:0] mc [3] = '{`FPS_CODE_MODEM_E1, `FPS_CODE_MODEM_E2, `FPS_CODE_RUN};
  assign ev = {sys_power_on, tone, alarm, screen_blank, mgmt_ctrl_reset, modem_init_req,
    host_nmi, host_hw_reset, host_os_shutdown_req};
  always #10 aclk = ~aclk;
  fps_panel_model pm_u (.aclk, .tone, .btn, .sens);
  fps_front_panel #(.DEB_CYC(4), .SEC_CYC(20), .SVC_IDLE_CYC(200), .FLASH_CYC(8)) dut_u (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .btn_power_on(btn[3]),
    .btn_standby(btn[2]), .btn_control(btn[1]), .btn_reset(btn[0]),
    .door_closed(sens[7]), .door_key_locked(sens[6]), .panel_removed(sens[5]),
    .token_card(sens[4]), .mains_ok(sens[3]), .batt_full(sens[2]), .batt_low(sens[1]),
    .batt_connected(sens[0]), .sys_power_on, .host_boot_release, .host_os_shutdown_req,
    .host_hw_reset, .host_nmi, .mgmt_ctrl_reset, .use_eprom_image, .modem_init_req,
    .lcd_code, .tone, .alarm, .screen_blank, .keyboard_disable, .led_power_green,
    .led_ups_green, .led_ups_amber
  );
  task close_out;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task chkb(input string n, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %b seen %b", n, e, g);
    end
  endtask
  task cyc_n(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task wait_ev(input int i, input logic v, input int n);
    int k;
    k = 0;
    while (ev[i] !== v && k < n) begin
      @(posedge aclk);
      k++;
    end
    chkb($sformatf("event %0d", i), v, ev[i]);
  endtask
  task press(input logic [3:0] m, input int n);
    pm_u.set_btn(m);
    cyc_n(n);
    pm_u.set_btn(4'h0);
    cyc_n(20);
  endtask
  task axw(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", `FPS_RESP_OKAY, s_axi_bresp);
  endtask
  task axr(input logic [3:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    rr = s_axi_rresp;
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    ev_q <= ev;
    for (int i = 0; i < 9; i++) begin
      if (ev[i] === 1'b1 && ev_q[i] !== 1'b1) rises[i]++;
    end
    if (cyc == 15000) begin
      err_total++;
      close_out();
    end
  end
  initial begin
    cyc_n(6);
    aresetn <= 1'b1;
    axr(`FPS_ADDR_CTRL);
    chk("ctrl", `FPS_CTRL_RESET, rd);
    axr(`FPS_ADDR_HOLD);
    chk("hold", {16'h0, `FPS_HOLD_DEF_S, `FPS_HOLD_DEF_S}, rd);
    axr(4'h2);
    chk("rresp", `FPS_RESP_SLVERR, rr);
    axw(`FPS_ADDR_LCD, 32'h1234);
    axr(`FPS_ADDR_LCD);
    chk("lcd ro", 32'h0, rd);
    $display("test registers done");
    press(4'h8, 12);
    wait_ev(8, 1'b1, 60);
    chkb("boot", 1'b1, host_boot_release);
    chkb("pled", 1'b1, led_power_green);
    pm_u.set_btn(4'h2);
    cyc_n(15);
    axw(`FPS_ADDR_CTRL, 32'h08);
    cyc_n(4);
    chkb("eprom", 1'b1, use_eprom_image);
    press(4'h2, 1);
    $display("test power on done");
    pm_u.set_btn(4'h1);
    cyc_n(20);
    chk("lcd", `FPS_CODE_RESET, lcd_code);
    chkb("tone", 1'b1, tone);
    press(4'h3, 100);
    chk("rst cancel", 0, rises[1]);
    pm_u.hold_tone(4'h1);
    cyc_n(10);
    chk("hw reset", 1, rises[1]);
    $display("test reset done");
    pm_u.set_btn(4'h4);
    cyc_n(20);
    chk("lcd", `FPS_CODE_STANDBY, lcd_code);
    chkb("tone", 1'b1, tone);
    press(4'h6, 150);
    chk("stby cancel", 0, rises[0]);
    chkb("on", 1'b1, sys_power_on);
    pm_u.hold_tone(4'h4);
    wait_ev(0, 1'b1, 10);
    wait_ev(8, 1'b0, 150);
    cyc_n(1);
    chkb("pled", 1'b0, led_power_green);
    chkb("eprom", 1'b0, use_eprom_image);
    $display("test standby done");
    press(4'h8, 12);
    wait_ev(8, 1'b1, 60);
    pm_u.set_btn(4'h7);
    cyc_n(20);
    chk("lcd", `FPS_CODE_SERVICE, lcd_code);
    press(4'h0, 1);
    press(4'h2, 12);
    chk("modem", 1, rises[3]);
    for (int i = 0; i < 3; i++) begin
      axw(`FPS_ADDR_CTRL, mw[i]);
      cyc_n(4);
      chk("modem code", mc[i], lcd_code);
    end
    pm_u.set_btn(4'h5);
    cyc_n(20);
    chk("lcd", `FPS_CODE_BLANK, lcd_code);
    press(4'h0, 1);
    chk("mgmt", 1, rises[4]);
    press(4'h7, 20);
    press(4'h4, 12);
    wait_ev(2, 1'b0, 1100);
    press(4'h7, 20);
    press(4'h1, 12);
    chk("nmi", 2, rises[2]);
    wait_ev(2, 1'b0, 1100);
    press(4'h7, 20);
    cyc_n(100);
    chk("svc stay", `FPS_CODE_SERVICE, lcd_code);
    cyc_n(150);
    chkb("svc exit", 1'b0, lcd_code === `FPS_CODE_SERVICE);
    $display("test service done");
    chkb("ups g", 1'b1, led_ups_green);
    pm_u.set_sens(8'h8B);
    cyc_n(20);
    rd[0] = led_ups_green;
    cyc_n(8);
    chkb("ups flash", ~rd[0], led_ups_green);
    pm_u.set_sens(8'h85);
    cyc_n(20);
    chkb("ups a", 1'b1, led_ups_amber);
    chkb("alarm", 1'b1, alarm);
    pm_u.set_sens(8'h8D);
    press(4'h2, 12);
    chkb("alarm", 1'b0, alarm);
    pm_u.set_sens(8'h8C);
    cyc_n(20);
    chk("ups off", 0, {led_ups_green, led_ups_amber});
    $display("test ups done");
    axw(`FPS_ADDR_CTRL, 32'h01);
    pm_u.set_sens(8'hCD);
    cyc_n(20);
    chk("armed", 32'h3, {alarm, screen_blank, keyboard_disable});
    press(4'h2, 12);
    chkb("alarm", 1'b1, alarm);
    for (int i = 0; i < 2; i++) begin
      pm_u.set_sens(8'hDD);
      cyc_n(20);
      pm_u.set_sens(8'hCD);
      cyc_n(20);
      chk("token", {1'b0, i[0], i[0]}, {alarm, screen_blank, keyboard_disable});
    end
    pm_u.set_sens(8'hED);
    cyc_n(20);
    chkb("alarm", 1'b1, alarm);
    pm_u.set_sens(8'h8D);
    cyc_n(20);
    chk("unlock", 32'h0, {alarm, screen_blank, keyboard_disable});
    $display("test security done");
    close_out();
  end
endmodule
`default_nettype wire
